// >>> spnf_defs.vh
// Shared constants of the source negotiation engine: state codes,
// message codes, evaluation answers and default timer counts.
// Assumes inclusion by bare name from each design file.
`ifndef SPNF_DEFS_VH
`define SPNF_DEFS_VH

// One-hot state codes, bit position order
`define SPNF_ST_W 10
`define SPNF_ST_BOOT 10'h001
`define SPNF_ST_EVAL 10'h002
`define SPNF_ST_SUPPLY 10'h004
`define SPNF_ST_STEADY 10'h008
`define SPNF_ST_INERT 10'h010
`define SPNF_ST_REFUSE 10'h020
`define SPNF_ST_LRESET 10'h040
`define SPNF_ST_RETDEF 10'h080
`define SPNF_ST_OFFER 10'h100
`define SPNF_ST_QUERY 10'h200

// Message codes towards the protocol layer
`define SPNF_MSG_W 4
`define SPNF_MSG_NONE 4'h0
`define SPNF_MSG_ACCEPT 4'h1
`define SPNF_MSG_GOTOMIN 4'h2
`define SPNF_MSG_PS_RDY 4'h3
`define SPNF_MSG_REJECT 4'h4
`define SPNF_MSG_WAIT 4'h5
`define SPNF_MSG_SRC_CAPS 4'h6
`define SPNF_MSG_GET_SNK_CAP 4'h7
`define SPNF_MSG_PING 4'h8

// Policy manager verdict on a sink request
`define SPNF_EVAL_MET 2'h0
`define SPNF_EVAL_NOT_MET 2'h1
`define SPNF_EVAL_LATER 2'h2

// Timer slots and default terminal counts in clock cycles
`define SPNF_TMR_N 4
`define SPNF_TMR_KEEPALIVE 0
`define SPNF_TMR_SILENCE 1
`define SPNF_TMR_REPLY 2
`define SPNF_TMR_SETTLE 3
`define SPNF_TMR_W 24
`define SPNF_KEEPALIVE_CYC 24'h00_1000
`define SPNF_SILENCE_CYC 24'h00_2000
`define SPNF_REPLY_CYC 24'h00_0800
`define SPNF_SETTLE_CYC 24'h00_0100

// Link reset tally width and default limit
`define SPNF_TALLY_W 4
`define SPNF_LINK_RESET_LIMIT 4'h2

`endif

// >>> spnf_timer.v
// Down-counting state timer with a one-cycle expiry pulse.
// Assumes load comes from registers of the owning engine; stop may also come straight from an engine input.
`timescale 1ns/1ps
`include "spnf_defs.vh"

module spnf_timer #(
    parameter W = `SPNF_TMR_W
) (
    clk,
    sys_rst,
    load,
    stop,
    limit,
    expired
);
    input wire clk;
    input wire sys_rst;
    input wire load;
    input wire stop;
    input wire [W-1:0] limit;
    output reg expired;

    reg [W-1:0] count_r;
    reg run_r;

    ////////////////////////////////////////////////////////////////////
    // Load wins over stop so a re-entry restarts the timer cleanly
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_r <= {W{1'b0}};
            run_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                count_r <= limit;
                run_r <= 1'b1;
            end else if (stop) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                // A limit of zero or one expires after one cycle
                if (count_r <= {{(W-1){1'b0}}, 1'b1}) begin
                    expired <= 1'b1;
                    run_r <= 1'b0;
                end else begin
                    count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// >>> spnf_engine.v
// Source-side power negotiation engine: evaluates sink requests,
// steps the supply, answers capability queries and runs link resets.
// Assumes single-cycle pulse inputs from the protocol layer, the
// physical layer and the policy manager, all on clk.
`timescale 1ns/1ps
`include "spnf_defs.vh"

module spnf_engine #(
    parameter [`SPNF_TMR_W-1:0] KEEPALIVE_CYC = `SPNF_KEEPALIVE_CYC,
    parameter [`SPNF_TMR_W-1:0] SILENCE_CYC = `SPNF_SILENCE_CYC,
    parameter [`SPNF_TMR_W-1:0] REPLY_CYC = `SPNF_REPLY_CYC,
    parameter [`SPNF_TMR_W-1:0] SETTLE_CYC = `SPNF_SETTLE_CYC,
    parameter [`SPNF_TALLY_W-1:0] LINK_RESET_LIMIT = `SPNF_LINK_RESET_LIMIT
) (
    input wire clk,
    input wire sys_rst,
    // Protocol layer indications
    input wire prl_request_rx,
    input wire prl_get_src_cap_rx,
    input wire prl_sink_caps_rx,
    input wire prl_tx_done,
    input wire prl_tx_fail,
    input wire prl_caps_goodcrc,
    // Physical layer
    input wire phy_hard_reset_rx,
    input wire phy_hard_reset_done,
    // Policy manager
    input wire pm_eval_valid,
    input wire [1:0] pm_eval_result,
    input wire pm_contract_valid,
    input wire pm_supply_ready,
    input wire pm_default_reached,
    input wire pm_goto_min,
    input wire pm_get_sink_caps,
    input wire pm_hard_reset_req,
    input wire pm_disable,
    // Outputs, all registered
    output reg [`SPNF_ST_W-1:0] src_state_r,
    output reg prl_tx_req_r,
    output reg [`SPNF_MSG_W-1:0] prl_tx_type_r,
    output reg prl_reset_req_r,
    output reg prl_hard_reset_complete_r,
    output reg phy_hard_reset_req_r,
    output reg pm_eval_req_r,
    output reg pm_supply_go_r,
    output reg pm_go_default_r,
    output reg hw_reset_req_r,
    output reg pm_caps_req_r,
    output reg pm_sink_caps_done_r,
    output reg pm_sink_caps_timeout_r,
    output reg offer_tally_clr_r,
    output reg default_power_r,
    output reg [`SPNF_TALLY_W-1:0] link_reset_tally_r
);

    ////////////////////////////////////////////////////////////////////
    // State bookkeeping
    reg enter_r;
    reg [1:0] phase_r;
    reg gotomin_r;
    reg [1:0] verdict_r;
    reg sent_wait_r;
    reg [`SPNF_TMR_N-1:0] tmr_load_r;
    wire [`SPNF_TMR_N-1:0] tmr_stop;
    wire [`SPNF_TMR_N-1:0] tmr_exp;
    wire [`SPNF_TMR_N*`SPNF_TMR_W-1:0] tmr_limit;

    wire in_supply = src_state_r[2];
    wire in_steady = src_state_r[3];
    wire in_query = src_state_r[9];
    wire ka_exp = tmr_exp[`SPNF_TMR_KEEPALIVE];
    wire silence_exp = tmr_exp[`SPNF_TMR_SILENCE];
    wire reply_exp = tmr_exp[`SPNF_TMR_REPLY];
    wire settle_exp = tmr_exp[`SPNF_TMR_SETTLE];
    wire tally_ok = (link_reset_tally_r <= LINK_RESET_LIMIT);

    ////////////////////////////////////////////////////////////////////
    // Timer limits and stops; state timers halt once their state is left, silence only on acknowledged caps
    assign tmr_limit = {SETTLE_CYC, REPLY_CYC, SILENCE_CYC, KEEPALIVE_CYC};
    assign tmr_stop[`SPNF_TMR_KEEPALIVE] = ~(in_supply | in_steady);
    assign tmr_stop[`SPNF_TMR_SILENCE] = prl_caps_goodcrc;
    assign tmr_stop[`SPNF_TMR_REPLY] = ~in_query;
    assign tmr_stop[`SPNF_TMR_SETTLE] = ~in_supply;

    genvar gi;
    generate
        for (gi = 0; gi < `SPNF_TMR_N; gi = gi + 1) begin : g_tmr
            spnf_timer #(
                .W(`SPNF_TMR_W)
            ) u_tmr (
                .clk(clk),
                .sys_rst(sys_rst),
                .load(tmr_load_r[gi]),
                .stop(tmr_stop[gi]),
                .limit(tmr_limit[gi*`SPNF_TMR_W +: `SPNF_TMR_W]),
                .expired(tmr_exp[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Link reset tally survives link resets; only acknowledged caps or
    // power-up clear it. A clear and an increment in the same cycle leave it at one.
    wire tally_bump = src_state_r[6] & enter_r;
    wire tally_full = &link_reset_tally_r;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_reset_tally_r <= {`SPNF_TALLY_W{1'b0}};
        end else if (tally_bump) begin
            if (prl_caps_goodcrc) begin
                link_reset_tally_r <= {{(`SPNF_TALLY_W-1){1'b0}}, 1'b1};
            end else if (!tally_full) begin
                link_reset_tally_r <= link_reset_tally_r + 1'b1;
            end
        end else if (prl_caps_goodcrc) begin
            link_reset_tally_r <= {`SPNF_TALLY_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main engine. Every move to a new state raises enter_r for one
    // cycle so the entry actions run exactly once.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_state_r <= `SPNF_ST_BOOT;
            enter_r <= 1'b1;
            phase_r <= 2'h0;
            gotomin_r <= 1'b0;
            verdict_r <= `SPNF_EVAL_MET;
            sent_wait_r <= 1'b0;
            tmr_load_r <= {`SPNF_TMR_N{1'b0}};
            prl_tx_req_r <= 1'b0;
            prl_tx_type_r <= `SPNF_MSG_NONE;
            prl_reset_req_r <= 1'b0;
            prl_hard_reset_complete_r <= 1'b0;
            phy_hard_reset_req_r <= 1'b0;
            pm_eval_req_r <= 1'b0;
            pm_supply_go_r <= 1'b0;
            pm_go_default_r <= 1'b0;
            hw_reset_req_r <= 1'b0;
            pm_caps_req_r <= 1'b0;
            pm_sink_caps_done_r <= 1'b0;
            pm_sink_caps_timeout_r <= 1'b0;
            offer_tally_clr_r <= 1'b0;
            default_power_r <= 1'b1;
        end else begin
            // Pulses default low
            enter_r <= 1'b0;
            tmr_load_r <= {`SPNF_TMR_N{1'b0}};
            prl_tx_req_r <= 1'b0;
            prl_reset_req_r <= 1'b0;
            prl_hard_reset_complete_r <= 1'b0;
            phy_hard_reset_req_r <= 1'b0;
            pm_eval_req_r <= 1'b0;
            pm_supply_go_r <= 1'b0;
            pm_go_default_r <= 1'b0;
            hw_reset_req_r <= 1'b0;
            pm_caps_req_r <= 1'b0;
            pm_sink_caps_done_r <= 1'b0;
            pm_sink_caps_timeout_r <= 1'b0;
            offer_tally_clr_r <= 1'b0;
            default_power_r <= src_state_r[4] | src_state_r[7] | src_state_r[0];

            // Far-end reset outranks everything outside return to default, inert state included
            if (phy_hard_reset_rx && !src_state_r[7]) begin
                src_state_r <= `SPNF_ST_RETDEF;
                enter_r <= 1'b1;
                phase_r <= 2'h0;
            end else if (silence_exp && tally_ok && !src_state_r[4]
                         && !src_state_r[6]) begin
                src_state_r <= `SPNF_ST_LRESET;
                enter_r <= 1'b1;
            end else if (pm_hard_reset_req && !src_state_r[6]
                         && !src_state_r[7]) begin
                // Policy reset requests rank after far-end reset and silence, ahead of all state events
                src_state_r <= `SPNF_ST_LRESET;
                enter_r <= 1'b1;
            end else begin
                case (src_state_r)
                    `SPNF_ST_BOOT: begin
                        if (enter_r) begin
                            offer_tally_clr_r <= 1'b1;
                            prl_reset_req_r <= 1'b1;
                        end else if (prl_request_rx) begin
                            src_state_r <= `SPNF_ST_EVAL;
                            enter_r <= 1'b1;
                        end else if (pm_disable) begin
                            src_state_r <= `SPNF_ST_INERT;
                            enter_r <= 1'b1;
                        end
                    end
                    `SPNF_ST_EVAL: begin
                        if (enter_r) begin
                            pm_eval_req_r <= 1'b1;
                            gotomin_r <= 1'b0;
                        end else if (pm_eval_valid) begin
                            verdict_r <= pm_eval_result;
                            enter_r <= 1'b1;
                            phase_r <= 2'h0;
                            if (pm_eval_result == `SPNF_EVAL_MET) begin
                                src_state_r <= `SPNF_ST_SUPPLY;
                            end else begin
                                src_state_r <= `SPNF_ST_REFUSE;
                            end
                        end
                    end
                    `SPNF_ST_SUPPLY: begin
                        if (enter_r) begin
                            tmr_load_r[`SPNF_TMR_KEEPALIVE] <= 1'b1;
                            prl_tx_req_r <= 1'b1;
                            prl_tx_type_r <= gotomin_r ? `SPNF_MSG_GOTOMIN
                                                       : `SPNF_MSG_ACCEPT;
                        end else begin
                            case (phase_r)
                                2'h0: begin
                                    // The settle delay counts from the send
                                    if (prl_tx_done) begin
                                        tmr_load_r[`SPNF_TMR_SETTLE] <= 1'b1;
                                        phase_r <= 2'h1;
                                    end
                                end
                                2'h1: begin
                                    if (settle_exp) begin
                                        pm_supply_go_r <= 1'b1;
                                        phase_r <= 2'h2;
                                    end
                                end
                                default: begin
                                    if (pm_supply_ready) begin
                                        prl_tx_req_r <= 1'b1;
                                        prl_tx_type_r <= `SPNF_MSG_PS_RDY;
                                        src_state_r <= `SPNF_ST_STEADY;
                                        enter_r <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                    `SPNF_ST_STEADY: begin
                        gotomin_r <= 1'b0;
                        if (enter_r) begin
                            tmr_load_r[`SPNF_TMR_KEEPALIVE] <= 1'b1;
                        end else if (prl_get_src_cap_rx) begin
                            src_state_r <= `SPNF_ST_OFFER;
                            enter_r <= 1'b1;
                        end else if (prl_request_rx) begin
                            src_state_r <= `SPNF_ST_EVAL;
                            enter_r <= 1'b1;
                        end else if (ka_exp) begin
                            // Keepalive ping, timer rearmed for the next one
                            prl_tx_req_r <= 1'b1;
                            prl_tx_type_r <= `SPNF_MSG_PING;
                            tmr_load_r[`SPNF_TMR_KEEPALIVE] <= 1'b1;
                        end else if (pm_goto_min) begin
                            gotomin_r <= 1'b1;
                            src_state_r <= `SPNF_ST_SUPPLY;
                            enter_r <= 1'b1;
                            phase_r <= 2'h0;
                        end else if (pm_get_sink_caps) begin
                            src_state_r <= `SPNF_ST_QUERY;
                            enter_r <= 1'b1;
                        end else if (pm_disable) begin
                            src_state_r <= `SPNF_ST_INERT;
                            enter_r <= 1'b1;
                        end
                    end
                    `SPNF_ST_INERT: begin
                        // Messages are not looked at; only a reset leaves
                        default_power_r <= 1'b1;
                    end
                    `SPNF_ST_REFUSE: begin
                        if (enter_r) begin
                            prl_tx_req_r <= 1'b1;
                            // An invalid contract never earns a Wait
                            if (verdict_r == `SPNF_EVAL_LATER && pm_contract_valid) begin
                                prl_tx_type_r <= `SPNF_MSG_WAIT;
                                sent_wait_r <= 1'b1;
                            end else begin
                                prl_tx_type_r <= `SPNF_MSG_REJECT;
                                sent_wait_r <= 1'b0;
                            end
                        end else if (prl_tx_done) begin
                            enter_r <= 1'b1;
                            if (sent_wait_r || pm_contract_valid) begin
                                src_state_r <= `SPNF_ST_STEADY;
                            end else begin
                                src_state_r <= `SPNF_ST_LRESET;
                            end
                        end else if (prl_tx_fail) begin
                            // Failed send: higher layers retry from steady
                            src_state_r <= `SPNF_ST_STEADY;
                            enter_r <= 1'b1;
                        end
                    end
                    `SPNF_ST_LRESET: begin
                        if (enter_r) begin
                            phy_hard_reset_req_r <= 1'b1;
                        end else if (phy_hard_reset_done) begin
                            src_state_r <= `SPNF_ST_RETDEF;
                            enter_r <= 1'b1;
                            phase_r <= 2'h0;
                        end
                    end
                    `SPNF_ST_RETDEF: begin
                        if (enter_r) begin
                            pm_go_default_r <= 1'b1;
                            phase_r <= 2'h1;
                        end else if (phase_r == 2'h1) begin
                            hw_reset_req_r <= 1'b1;
                            phase_r <= 2'h2;
                        end else if (pm_default_reached) begin
                            tmr_load_r[`SPNF_TMR_SILENCE] <= 1'b1;
                            prl_hard_reset_complete_r <= 1'b1;
                            src_state_r <= `SPNF_ST_BOOT;
                            enter_r <= 1'b1;
                        end
                    end
                    `SPNF_ST_OFFER: begin
                        if (enter_r) begin
                            pm_caps_req_r <= 1'b1;
                            prl_tx_req_r <= 1'b1;
                            prl_tx_type_r <= `SPNF_MSG_SRC_CAPS;
                        end else if (prl_tx_done || prl_tx_fail) begin
                            src_state_r <= `SPNF_ST_STEADY;
                            enter_r <= 1'b1;
                        end
                    end
                    `SPNF_ST_QUERY: begin
                        if (enter_r) begin
                            prl_tx_req_r <= 1'b1;
                            prl_tx_type_r <= `SPNF_MSG_GET_SNK_CAP;
                            tmr_load_r[`SPNF_TMR_REPLY] <= 1'b1;
                        end else if (prl_sink_caps_rx) begin
                            // A reply beats a timeout in the same cycle
                            pm_sink_caps_done_r <= 1'b1;
                            src_state_r <= `SPNF_ST_STEADY;
                            enter_r <= 1'b1;
                        end else if (reply_exp) begin
                            pm_sink_caps_done_r <= 1'b1;
                            pm_sink_caps_timeout_r <= 1'b1;
                            src_state_r <= `SPNF_ST_STEADY;
                            enter_r <= 1'b1;
                        end
                    end
                    default: begin
                        src_state_r <= `SPNF_ST_BOOT;
                        enter_r <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// >>> spnf_engine_chk.sv
// Port checker for the source negotiation engine.
// Assumes binding into spnf_engine; sees its ports only.
`timescale 1ns/1ps
`include "spnf_defs.vh"
////////////////////////////////////////
module spnf_engine_chk (
    input wire clk,
    input wire sys_rst,
    input wire phy_hard_reset_rx,
    input wire pm_hard_reset_req,
    input wire pm_contract_valid,
    input wire [9:0] src_state_r,
    input wire prl_tx_req_r,
    input wire [3:0] prl_tx_type_r,
    input wire prl_reset_req_r,
    input wire offer_tally_clr_r,
    input wire phy_hard_reset_req_r,
    input wire pm_eval_req_r,
    input wire pm_go_default_r,
    input wire hw_reset_req_r,
    input wire default_power_r,
    input wire [3:0] link_reset_tally_r
);
    // Reset parks the state in boot, so $rose never fires on release
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_eval_ask; $rose(src_state_r[1]) |=> pm_eval_req_r; endproperty
    a_eval_ask: assert property (p_eval_ask) else $error("no verdict request");
    property p_ps_rdy; $rose(src_state_r[3]) && $past(src_state_r[2])
        |-> prl_tx_req_r && prl_tx_type_r == `SPNF_MSG_PS_RDY; endproperty
    a_ps_rdy: assert property (p_ps_rdy) else $error("no ready message");
    property p_no_wait; $rose(src_state_r[5]) && !pm_contract_valid
        |=> prl_tx_req_r && prl_tx_type_r == `SPNF_MSG_REJECT; endproperty
    a_no_wait: assert property (p_no_wait) else $error("invalid contract not rejected");
    property p_link_rst; $rose(src_state_r[6]) && link_reset_tally_r != 4'hf
        |=> phy_hard_reset_req_r && link_reset_tally_r == $past(link_reset_tally_r) + 4'h1;
    endproperty
    a_link_rst: assert property (p_link_rst) else $error("link reset entry wrong");
    property p_far_rst; phy_hard_reset_rx && !src_state_r[7] |=> src_state_r[7]; endproperty
    a_far_rst: assert property (p_far_rst) else $error("far reset missed");
    property p_retdef; $rose(src_state_r[7]) |=> pm_go_default_r ##1 hw_reset_req_r; endproperty
    a_retdef: assert property (p_retdef) else $error("default return entry wrong");
    property p_boot; $rose(src_state_r[0]) |=> prl_reset_req_r && offer_tally_clr_r; endproperty
    a_boot: assert property (p_boot) else $error("boot entry wrong");
    property p_inert; src_state_r[4] && !phy_hard_reset_rx && !pm_hard_reset_req
        |=> src_state_r[4] && default_power_r; endproperty
    a_inert: assert property (p_inert) else $error("inert state left");
endmodule
////////////////////////////////////////
bind spnf_engine spnf_engine_chk u_chk (.*);

// >>> spnf_far_end.sv
// Far side model: protocol layer and attached sink answering sends.
// Assumes the engine's requests are one-cycle pulses on clk.
`timescale 1ns/1ps
////////////////////////////////////////
module spnf_far_end (
    input wire clk,
    input wire sys_rst,
    input wire slow,
    input wire fail,
    input wire prl_tx_req_r,
    input wire phy_hard_reset_req_r,
    output wire prl_tx_done,
    output wire prl_tx_fail,
    output wire phy_hard_reset_done
);
    int tc, hc;
    // Count down from each request; slow mode stretches the send
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tc <= 0;
            hc <= 0;
        end else begin
            tc <= prl_tx_req_r ? (slow ? 12 : 3) : (tc > 0 ? tc - 1 : 0);
            hc <= phy_hard_reset_req_r ? 5 : (hc > 0 ? hc - 1 : 0);
        end
    end
    // One-cycle replies; fail mode turns the reply into a failure
    assign prl_tx_done = (tc == 1) && !fail;
    assign prl_tx_fail = (tc == 1) && fail;
    assign phy_hard_reset_done = (hc == 1);
endmodule

// >>> spnf_engine_test.sv
// Self-checking bench for the source negotiation engine.
// Assumes spnf_far_end answers sends and link resets.
`timescale 1ns/1ps
`include "spnf_defs.vh"
////////////////////////////////////////
module spnf_engine_test;
    localparam [23:0] KA = 24'h00_00c8;
    localparam [23:0] ST = 24'h00_0008;
    logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, pm_contract_valid = 1'b1, fail = 1'b0;
    logic pm_supply_ready = 1'b0, pm_default_reached = 1'b0;
    logic [1:0] pm_eval_result = 2'h0;
    logic [9:0] ev = 10'h000, tgt = 10'h000;
    wire prl_request_rx, prl_get_src_cap_rx, prl_sink_caps_rx, prl_caps_goodcrc;
    wire phy_hard_reset_rx, pm_eval_valid, pm_goto_min, pm_get_sink_caps, pm_hard_reset_req;
    wire pm_disable, prl_tx_done, prl_tx_fail, phy_hard_reset_done, prl_tx_req_r;
    wire prl_reset_req_r, prl_hard_reset_complete_r, phy_hard_reset_req_r, pm_eval_req_r;
    wire pm_supply_go_r, pm_go_default_r, hw_reset_req_r, pm_caps_req_r, pm_sink_caps_done_r;
    wire pm_sink_caps_timeout_r, offer_tally_clr_r, default_power_r;
    wire [9:0] src_state_r;
    wire [3:0] prl_tx_type_r, link_reset_tally_r;
    wire [2:0] ob = {pm_sink_caps_done_r, pm_supply_go_r, prl_tx_req_r};
    int error_cnt = 0, compares = 0, tl = 0, n;
    // Event pulses by index so one task raises any of them
    assign {pm_disable, pm_hard_reset_req, pm_get_sink_caps, pm_goto_min, pm_eval_valid,
        phy_hard_reset_rx, prl_caps_goodcrc, prl_sink_caps_rx, prl_get_src_cap_rx,
        prl_request_rx} = ev;
    spnf_engine #(.KEEPALIVE_CYC(KA), .SILENCE_CYC(24'h00_0258), .REPLY_CYC(24'h00_0014),
        .SETTLE_CYC(ST)) DUT (.*);
    spnf_far_end u_far (.*);
    always #2 clk = ~clk;
    ////////////////////////////////////////
    task chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task pulse(input int b);
        @(negedge clk);
        ev[b] = 1'b1;
        @(negedge clk);
        ev = 10'h000;
    endtask
    // Bounded wait; k picks a pulse of ob, 3 the state in tgt
    task wt(input int k);
        n = 0;
        while ((k == 3 ? src_state_r !== tgt : ob[k] !== 1'b1) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 3000, "wait ran out");
        if (n == 3000)
            wrap_up;
    endtask
    task ws(input [9:0] s);
        tgt = s;
        wt(3);
    endtask
    ////////////////////////////////////////
    task nego(input [1:0] v, input cv);
        pm_eval_result = v;
        pm_contract_valid = cv;
        pulse(0);
        ws(`SPNF_ST_EVAL);
        @(negedge clk);
        chk(pm_eval_req_r === 1'b1, "no verdict ask");
        pulse(5);
    endtask
    task sup(input [3:0] t);
        wt(0);
        chk(prl_tx_type_r === t, "supply message");
        wt(1);
        chk(n > ST && n < ST + 20, "settle delay");
        pm_supply_ready = 1'b1;
        wt(0);
        chk(src_state_r === `SPNF_ST_STEADY, "not steady");
        pm_supply_ready = 1'b0;
    endtask
    // Link reset then return to default; tally kept across resets
    task hr;
        ws(`SPNF_ST_LRESET);
        tl++;
        @(negedge clk);
        chk(link_reset_tally_r === tl[3:0], "tally");
        ws(`SPNF_ST_RETDEF);
        pm_default_reached = 1'b1;
        ws(`SPNF_ST_BOOT);
        pm_default_reached = 1'b0;
        chk(prl_hard_reset_complete_r === 1'b1, "no completion");
    endtask
    task t_met;
        nego(`SPNF_EVAL_MET, 1'b1);
        ws(`SPNF_ST_SUPPLY);
        sup(`SPNF_MSG_ACCEPT);
    endtask
    task t_ping;
        @(negedge clk);
        wt(0);
        chk(prl_tx_type_r === `SPNF_MSG_PING && n > KA - 8 && n < KA + 8, "ping");
    endtask
    task t_offer;
        slow = 1'b1;
        pulse(1);
        ws(`SPNF_ST_OFFER);
        wt(0);
        chk(prl_tx_type_r === `SPNF_MSG_SRC_CAPS && pm_caps_req_r === 1'b1, "caps");
        ws(`SPNF_ST_STEADY);
        chk(n > 9, "left before sent");
        slow = 1'b0;
    endtask
    task t_query(input logic to);
        pulse(7);
        ws(`SPNF_ST_QUERY);
        wt(0);
        chk(prl_tx_type_r === `SPNF_MSG_GET_SNK_CAP, "query message");
        if (!to)
            pulse(2);
        wt(2);
        chk(pm_sink_caps_timeout_r === to && (to ? n > 15 : n < 4), "outcome");
        chk(src_state_r === `SPNF_ST_STEADY, "query exit");
    endtask
    task t_refuse(input [1:0] v, input cv);
        logic [3:0] e;
        e = (v == `SPNF_EVAL_LATER && cv) ? `SPNF_MSG_WAIT : `SPNF_MSG_REJECT;
        nego(v, cv);
        ws(`SPNF_ST_REFUSE);
        wt(0);
        chk(prl_tx_type_r === e, "refusal message");
        if (e == `SPNF_MSG_WAIT || cv)
            ws(`SPNF_ST_STEADY);
        else
            hr;
    endtask
    task t_goodcrc;
        pulse(3);
        tl = 0;
        chk(link_reset_tally_r === 4'h0, "tally kept");
    endtask
    task t_inert;
        pulse(9);
        ws(`SPNF_ST_INERT);
        pulse(0);
        chk(src_state_r === `SPNF_ST_INERT && default_power_r === 1'b1, "inert");
        pulse(4);
        ws(`SPNF_ST_RETDEF);
        pm_default_reached = 1'b1;
        ws(`SPNF_ST_BOOT);
        pm_default_reached = 1'b0;
    endtask
    ////////////////////////////////////////
    // Silence test last: once armed it would cut into other scenarios
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        chk(link_reset_tally_r === 4'h0 && prl_tx_type_r === 4'h0, "reset values");
        t_met;
        t_ping;
        t_offer;
        t_query(1'b0);
        t_query(1'b1);
        pulse(6);
        ws(`SPNF_ST_SUPPLY);
        sup(`SPNF_MSG_GOTOMIN);
        t_refuse(`SPNF_EVAL_NOT_MET, 1'b1);
        t_refuse(`SPNF_EVAL_LATER, 1'b1);
        fail = 1'b1;
        nego(`SPNF_EVAL_NOT_MET, 1'b0);
        ws(`SPNF_ST_REFUSE);
        ws(`SPNF_ST_STEADY);
        fail = 1'b0;
        t_refuse(`SPNF_EVAL_LATER, 1'b0);
        t_met;
        pulse(8);
        hr;
        t_goodcrc;
        t_met;
        t_inert;
        hr;
        wrap_up;
    end
endmodule
